// File: core/acm_pkg.sv
// constants, carrier types and states of the converter capture engine
// assumes one 125 MHz clock shared by the capture logic and its host slave
package acm_pkg;
  // ************************************************************
  // widths and sizes
  // ************************************************************
  localparam int ADC_W = 14;
  localparam int DATA_W = 32;
  localparam int CNT_W = 20;
  localparam int ADDR_W = 32;
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  // ************************************************************
  // register indexes and values
  // ************************************************************
  localparam logic REG_CTRL = 1'h0;
  localparam logic REG_STAT = 1'h1;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0;
  localparam logic [DATA_W-1:0] STAT_RST = 32'h0;
  localparam logic [ADDR_W-1:0] MEM_BASE = 32'h0;
  localparam logic [ADDR_W-1:0] WORD_STEP = 32'h4;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h1;
  localparam logic [ADC_W-1:0] DUMMY_RST = 14'h0;
  localparam logic [ADC_W-1:0] DUMMY_STEP = 14'h1;

  typedef struct packed {
    logic start;
    logic dummy;
    logic [9:0] rsvd;
    logic [CNT_W-1:0] count;
  } acm_ctrl_t;

  typedef struct packed {
    logic [28:0] rsvd;
    logic oor;
    logic ovf;
    logic done;
  } acm_stat_t;

  typedef struct packed {
    logic oor;
    logic [ADC_W-1:0] data;
  } acm_sample_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPT = 2'b01,
    ST_DRAIN = 2'b10
  } acm_state_t;
endpackage

// File: core/acm_fifo.sv
// sample buffer between capture and memory writer
// assumes single clock, producer and consumer both on mclk
module acm_fifo
  import acm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [acm_pkg::DATA_W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [acm_pkg::DATA_W-1:0] out_data
);
  logic [DATA_W-1:0] mem [FIFO_DEPTH];
  logic [FIFO_AW:0] wr_ptr;
  logic [FIFO_AW:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {FIFO_AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[FIFO_AW-1:0]];

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr[FIFO_AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// File: core/acm_capture.sv
// capture engine: converter pins in, on-chip memory writes out
// assumes the memory behind the master belongs to this instance alone
module acm_capture (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // converter pins
  input wire logic [acm_pkg::ADC_W-1:0] adc_data,
  input wire logic adc_oor,
  // host slave port
  input wire logic avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [acm_pkg::DATA_W-1:0] avs_writedata,
  output logic [acm_pkg::DATA_W-1:0] avs_readdata,
  // memory master port
  output logic [acm_pkg::ADDR_W-1:0] avm_address,
  output logic avm_write,
  output logic [acm_pkg::DATA_W-1:0] avm_writedata,
  input wire logic avm_waitrequest
);
  import acm_pkg::*;

  acm_ctrl_t ctrl;
  acm_stat_t stat;
  acm_state_t state;
  acm_sample_t pin_s1;
  acm_sample_t pin_s2;
  acm_sample_t pin_s3;
  acm_sample_t smp;
  logic [CNT_W-1:0] cap_cnt;
  logic [ADC_W-1:0] dummy_val;
  logic [ADC_W-1:0] sel_val;
  logic [ADDR_W-1:0] wr_addr;
  logic start_wr;
  logic push_valid;
  logic push_ready;
  logic [DATA_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [DATA_W-1:0] pop_data;
  logic overflow;
  logic range_hit;
  logic drain_done;

  // ************************************************************
  // converter pin synchroniser
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= '{oor: adc_oor, data: adc_data};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // value accepted once stages two and three agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smp <= '0;
    end else if (pin_s2 == pin_s3) begin
      smp <= pin_s3;
    end
  end

  // ************************************************************
  // host slave port
  // ************************************************************
  assign start_wr = avs_write && avs_address == REG_CTRL && avs_writedata[DATA_W-1] &&
                    state == ST_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
    end else if (avs_write && avs_address == REG_CTRL && state == ST_IDLE) begin
      ctrl <= avs_writedata;
      ctrl.rsvd <= '0;
    end
  end

  // fixed read latency of one cycle; start bit reads as busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read) begin
      if (avs_address == REG_CTRL) begin
        avs_readdata <= {state != ST_IDLE, ctrl.dummy, 10'h0, ctrl.count};
      end else begin
        avs_readdata <= stat;
      end
    end
  end

  // ************************************************************
  // capture sequence
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cap_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cap_cnt <= '0;
          if (start_wr) begin
            state <= (avs_writedata[CNT_W-1:0] == '0) ? ST_DRAIN : ST_CAPT;
          end
        end
        ST_CAPT: begin
          cap_cnt <= cap_cnt + CNT_ONE;
          if (cap_cnt == ctrl.count - CNT_ONE) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (drain_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // test pattern counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dummy_val <= DUMMY_RST;
    end else if (start_wr) begin
      dummy_val <= DUMMY_RST;
    end else if (state == ST_CAPT) begin
      dummy_val <= dummy_val + DUMMY_STEP;
    end
  end

  assign sel_val = ctrl.dummy ? dummy_val : smp.data;
  assign push_valid = state == ST_CAPT;
  assign push_data = {{(DATA_W - ADC_W){sel_val[ADC_W-1]}}, sel_val};
  assign overflow = push_valid && !push_ready;
  assign range_hit = push_valid && !ctrl.dummy && smp.oor;
  assign drain_done = state == ST_DRAIN && !pop_valid && !avm_write;

  // ************************************************************
  // sample FIFO
  // ************************************************************
  acm_fifo u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // ************************************************************
  // memory writer
  // ************************************************************
  assign pop_ready = !avm_write || !avm_waitrequest;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avm_write <= 1'b0;
      avm_address <= MEM_BASE;
      avm_writedata <= '0;
      wr_addr <= MEM_BASE;
    end else if (start_wr) begin
      wr_addr <= MEM_BASE;
    end else if (pop_ready) begin
      avm_write <= pop_valid;
      if (pop_valid) begin
        avm_address <= wr_addr;
        avm_writedata <= pop_data;
        wr_addr <= wr_addr + WORD_STEP;
      end
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat <= STAT_RST;
    end else begin
      if (start_wr) begin
        stat <= STAT_RST;
      end
      if (drain_done) begin
        stat.done <= 1'b1;
      end
      if (overflow) begin
        stat.ovf <= 1'b1;
      end
      if (range_hit) begin
        stat.oor <= 1'b1;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_start_clear;
    @(posedge mclk) disable iff (rst) start_wr |=> stat == STAT_RST;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start left a flag set");

  property p_done_src;
    @(posedge mclk) disable iff (rst)
      $rose(stat.done) |-> $past(state) == ST_DRAIN && state == ST_IDLE && !avm_write;
  endproperty
  a_done_src: assert property (p_done_src) else $error("done set before drain end");

  property p_ovf;
    @(posedge mclk) disable iff (rst) push_valid && !push_ready |=> stat.ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_oor;
    @(posedge mclk) disable iff (rst) state == ST_CAPT && !ctrl.dummy && smp.oor |=> stat.oor;
  endproperty
  a_oor: assert property (p_oor) else $error("out of range not flagged");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      avm_write && avm_waitrequest |=>
        avm_write && $stable(avm_writedata) && $stable(avm_address);
  endproperty
  a_hold: assert property (p_hold) else $error("write dropped under wait");

  property p_addr_step;
    @(posedge mclk) disable iff (rst)
      avm_write && !avm_waitrequest ##1 avm_write |-> avm_address == $past(avm_address) + 32'h4;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not consecutive");

  property p_dummy;
    @(posedge mclk) disable iff (rst)
      state == ST_CAPT ##1 state == ST_CAPT |-> dummy_val == $past(dummy_val) + 14'h1;
  endproperty
  a_dummy: assert property (p_dummy) else $error("test pattern not stepping");

  property p_ctrl_wr;
    @(posedge mclk) disable iff (rst)
      avs_write && avs_address == REG_CTRL && state == ST_IDLE |=>
        ctrl.count == $past(avs_writedata[19:0]) && ctrl.rsvd == '0;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("count not stored");

  property p_run;
    @(posedge mclk) disable iff (rst)
      start_wr && avs_writedata[19:0] != 20'h0 |=> state == ST_CAPT;
  endproperty
  a_run: assert property (p_run) else $error("start did not begin capture");

  property p_stat_rd;
    @(posedge mclk) disable iff (rst)
      avs_read && avs_address == REG_STAT |=> avs_readdata == {29'h0, $past(stat[2:0])};
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read mismatch");
endmodule

// File: test/acm_adc_model.sv
// converter chip model feeding the capture engine pins
// assumes the bench sets the analog level and the range flag
module acm_adc_model (
  // clock
  input wire logic mclk,
  // analog stimulus from bench
  input wire logic [acm_pkg::ADC_W-1:0] level,
  input wire logic over,
  // converter pins
  output logic [acm_pkg::ADC_W-1:0] adc_data,
  output logic adc_oor
);
  timeunit 1ns;
  timeprecision 1ps;
  import acm_pkg::*;
  // ************************************************************
  // output register, one conversion per clock
  // ************************************************************
  always_ff @(posedge mclk) begin
    adc_data <= level;
    adc_oor <= over;
  end
endmodule

// File: test/tb_top.sv
// self-checking bench of the capture engine
// assumes the converter model and a bench memory with stalls
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acm_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic mclk = 1'b0;
  logic rst, avs_address, avs_read, avs_write, avm_write, avm_waitrequest;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, avm_writedata, got;
  logic [ADDR_W-1:0] avm_address;
  logic [ADC_W-1:0] level, adc_data;
  logic over, adc_oor, stall, slow;
  logic [31:0] addr_q[$], data_q[$];
  int err_count, checks;

  always #4 mclk = ~mclk;

  acm_adc_model conv (.mclk(mclk), .level(level), .over(over),
    .adc_data(adc_data), .adc_oor(adc_oor));

  acm_capture dut (.mclk(mclk), .rst(rst), .adc_data(adc_data),
    .adc_oor(adc_oor), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avm_address(avm_address),
    .avm_write(avm_write), .avm_writedata(avm_writedata),
    .avm_waitrequest(avm_waitrequest));

  // ************************************************************
  // memory: stalls on demand, records accepted words
  // ************************************************************
  always @(posedge mclk) begin
    avm_waitrequest <= stall | (slow & ~avm_waitrequest);
    if (avm_write === 1'b1 && avm_waitrequest === 1'b0) begin
      addr_q.push_back(avm_address);
      data_q.push_back(avm_writedata);
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= 1'b1;
    avs_writedata <= d;
    @(posedge mclk);
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic a);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    avs_read <= 1'b0;
    #1 got = avs_readdata;
  endtask

  task automatic wait_done;
    int i;
    i = 0;
    do begin
      rd(1'b1);
      i++;
    end while (got[0] !== 1'b1 && i < 300);
  endtask

  task automatic chk_mem(input int n, input logic [13:0] first, input logic step);
    logic [13:0] v;
    chk(32'(addr_q.size()), 32'(n));
    foreach (addr_q[i]) begin
      v = first + (step ? 14'(i) : 14'h0);
      chk(addr_q[i], 32'(i * 4));
      chk(data_q[i], {{18{v[13]}}, v});
    end
    addr_q.delete();
    data_q.delete();
  endtask

  task automatic results;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd(1'b0);
    chk(got, 32'h0);
    wr(1'b1, 32'hFFFFFFFF);
    rd(1'b1);
    chk(got, 32'h0);
  endtask

  task automatic t_dummy;
    slow <= 1'b1;
    wr(1'b0, 32'hC0000004);
    rd(1'b0);
    chk(got, 32'hC0000004);
    wait_done;
    chk(got, 32'h1);
    chk_mem(4, 14'h0, 1'b1);
  endtask

  task automatic t_real;
    slow <= 1'b0;
    level <= 14'h2ABC;
    over <= 1'b1;
    repeat (5) @(posedge mclk);
    wr(1'b0, 32'h80000003);
    wait_done;
    chk(got, 32'h5);
    chk_mem(3, 14'h2ABC, 1'b0);
    over <= 1'b0;
    // let the cleared range flag pass the pin synchroniser
    repeat (5) @(posedge mclk);
  endtask

  task automatic t_ovf;
    stall <= 1'b1;
    wr(1'b0, 32'h80000028);
    repeat (50) @(posedge mclk);
    rd(1'b1);
    chk(got, 32'h2);
    // control write while busy is ignored
    wr(1'b0, 32'hC0000005);
    rd(1'b0);
    chk(got, 32'h80000028);
    stall <= 1'b0;
    wait_done;
    chk(got, 32'h3);
    chk(32'(addr_q.size() < 40), 32'h1);
    addr_q.delete();
    data_q.delete();
  endtask

  task automatic t_clear;
    wr(1'b0, 32'hBFF00000);
    wait_done;
    chk(got, 32'h1);
    rd(1'b0);
    chk(got, 32'h0);
    chk(32'(addr_q.size()), 32'h0);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    rst = 1'b1;
    avs_address = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    level = 14'h0;
    over = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_dummy;
    t_real;
    t_ovf;
    t_clear;
    results;
  end

  initial begin
    #200000;
    err_count++;
    results;
  end
endmodule
